//--- shared/spm_pkg.sv
/*
 * Package for the serial port mode-control slice: register offset,
 * field positions, reset value, clock-select encodings and carriers.
 * Assumes a 32-bit classic Wishbone slave with word-aligned registers.
 */
package spm_pkg;

   // ************************************************************
   // Register map
   // ************************************************************
   localparam logic [7:0]  SPM_MODE_OFS   = 8'h00;
   localparam logic [7:0]  SPM_CTRL_OFS   = 8'h04;
   localparam logic [31:0] SPM_MODE_RST   = 32'h0000_0000;
   localparam logic [31:0] SPM_CTRL_RST   = 32'h0000_0000;

   // ************************************************************
   // Mode register field positions
   // ************************************************************
   localparam int SPM_RUN_SLEEP_BIT = 23;
   localparam int SPM_ACTIVE_BIT    = 22;
   localparam int SPM_CLKSEL_LO     = 17;
   localparam int SPM_OVF_RUN_BIT   = 16;
   localparam int SPM_ENABLE_BIT    = 15;
   localparam int SPM_IDLE_STOP_BIT = 13;
   localparam int SPM_IR_EN_BIT     = 12;
   localparam int SPM_TX_EN_BIT     = 10;
   localparam int SPM_PIN_EN_LO     = 8;

   // Writable bits: 23, 18:15, 13:0 (22 is status, rest unimplemented)
   localparam logic [31:0] SPM_MODE_WMASK = 32'h0087_bfff;

   // Control register: power mode request bits
   localparam int SPM_CTRL_SLEEP_BIT = 0;
   localparam int SPM_CTRL_IDLE_BIT  = 1;

   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [1:0] {
      SPM_CLK_PBUS = 2'h0,
      SPM_CLK_SYS  = 2'h1,
      SPM_CLK_FRC  = 2'h2,
      SPM_CLK_REF  = 2'h3
   } spm_clksel_type;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } spm_wb_req_type;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } spm_wb_rsp_type;

   // Pin ownership towards the I/O pad logic
   typedef struct packed {
      logic       port_owns;     // Port drives the pins
      logic       tx_oe;         // Transmit pin output enable
      logic [1:0] pin_enable;    // Legacy field, routing is by pin select
   } spm_pin_type;

endpackage : spm_pkg

//--- core/spm_mode_ctrl.sv
/*
 * Mode-control slice of an asynchronous serial port.
 * Assumes: the four candidate clocks arrive as one-cycle enables in the
 * mclk domain; the serial engine reports its busy and overflow states.
 */
// Decided for this implementation: register access over Wishbone and the address map.
`timescale 1ns/1ns

module spm_mode_ctrl
   import spm_pkg::*;
(
   input  wire logic           mclk,          // 10 MHz system clock
   input  wire logic           rstn,          // Async reset, active low
   input  wire spm_wb_req_type wb_req,        // Wishbone request
   output      spm_wb_rsp_type wb_rsp,        // Wishbone answer
   input  wire logic           pbus_ce,       // Peripheral bus clock enable
   input  wire logic           sys_ce,        // System clock enable
   input  wire logic           frc_ce,        // Fast RC oscillator enable
   input  wire logic           ref_ce,        // Reference clock enable
   input  wire logic           engine_busy,   // Serial engine busy
   input  wire logic           rx_overflow,   // Receive overflow error
   input  wire logic           rx_in,         // Raw receive line
   input  wire logic           tx_raw,        // Engine transmit bit
   input  wire logic           ir_tx_pulse,   // Encoder output
   input  wire logic           ir_rx_bit,     // Decoder output
   output      logic           port_ce,       // Gated port clock enable
   output      logic           shift_accept,  // Receive shifter may run
   output      logic           rx_to_engine,  // Receive bit to engine
   output      logic           tx_out,        // Transmit pin value
   output      logic           ir_active,     // Infrared path in use
   output      spm_pin_type    pins           // Pin ownership
);

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      logic [31:0] mode;
      logic [1:0]  pwr;
      logic        ack;
      logic [31:0] rdat;
      logic        active;
   } spm_state_type;

   spm_state_type st_q;
   spm_state_type st_d;

   logic           req_hit;
   logic           sleeping;
   logic           idling;
   logic           src_ce;
   logic           run_ok;
   logic [31:0]    wr_bits;
   logic [31:0]    pwr_bits;
   spm_clksel_type csel;

   // Byte-lane merge of a write into an old value, used for both regs
   function automatic logic [31:0] spm_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction : spm_merge

   // ************************************************************
   // Clock source and power gating
   // ************************************************************
   assign csel     = spm_clksel_type'(st_q.mode[SPM_CLKSEL_LO +: 2]);
   assign sleeping = st_q.pwr[SPM_CTRL_SLEEP_BIT];
   assign idling   = st_q.pwr[SPM_CTRL_IDLE_BIT];

   always_comb begin
      unique case (csel)
         SPM_CLK_PBUS: src_ce = pbus_ce;
         SPM_CLK_SYS:  src_ce = sys_ce;
         SPM_CLK_FRC:  src_ce = frc_ce;
         SPM_CLK_REF:  src_ce = ref_ce;
      endcase
   end

   // run permission: sleep, idle and enable gating
   assign run_ok = st_q.mode[SPM_ENABLE_BIT]
                   && !(sleeping && !st_q.mode[SPM_RUN_SLEEP_BIT])
                   && !(idling && st_q.mode[SPM_IDLE_STOP_BIT]);

   // Gating the enable, not the clock, keeps one clock domain
   assign port_ce = run_ok && src_ce;

   assign shift_accept = run_ok
                         && (!rx_overflow || st_q.mode[SPM_OVF_RUN_BIT]);

   // ************************************************************
   // Infrared path and pins
   // ************************************************************
   // infrared encoder/decoder switch
   assign ir_active    = st_q.mode[SPM_ENABLE_BIT] && st_q.mode[SPM_IR_EN_BIT];
   assign rx_to_engine = ir_active ? ir_rx_bit : rx_in;

   // pin ownership; idle line is high when not driven by data
   always_comb begin
      pins.port_owns  = st_q.mode[SPM_ENABLE_BIT];
      pins.tx_oe      = st_q.mode[SPM_ENABLE_BIT] && st_q.mode[SPM_TX_EN_BIT];
      pins.pin_enable = st_q.mode[SPM_PIN_EN_LO +: 2];
      if (!pins.tx_oe) begin
         tx_out = 1'b1;
      end else if (ir_active) begin
         tx_out = ir_tx_pulse;
      end else begin
         tx_out = tx_raw;
      end
   end

   // ************************************************************
   // Wishbone slave and next state
   // ************************************************************
   assign req_hit = wb_req.cyc && wb_req.stb && !st_q.ack;
   assign wr_bits = spm_merge(st_q.mode, wb_req.dat, wb_req.sel);
   // Power request merge; only the low two bits are kept
   assign pwr_bits = spm_merge({30'h0, st_q.pwr}, wb_req.dat, wb_req.sel);

   // Single-wait answer: ack one cycle after the request, then dropped
   always_comb begin
      st_d        = st_q;
      st_d.ack    = req_hit;
      // running status follows the engine and enable
      st_d.active = st_q.mode[SPM_ENABLE_BIT] && engine_busy;
      if (req_hit && wb_req.we) begin
         if (wb_req.adr == SPM_MODE_OFS) begin
            st_d.mode = wr_bits & SPM_MODE_WMASK;
         end else if (wb_req.adr == SPM_CTRL_OFS) begin
            st_d.pwr = pwr_bits[1:0];
         end
      end
      if (req_hit) begin
         if (wb_req.adr == SPM_MODE_OFS) begin
            // status bit merged, reserved read zero
            st_d.rdat = (st_q.mode & SPM_MODE_WMASK)
                        | ({31'h0, st_q.active} << SPM_ACTIVE_BIT);
         end else if (wb_req.adr == SPM_CTRL_OFS) begin
            st_d.rdat = {30'h0, st_q.pwr};
         end else begin
            st_d.rdat = 32'h0;   // Unmapped reads zero, write ignored
         end
      end
   end

   // reset to zero, port off, bus clock selected
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         st_q.mode   <= SPM_MODE_RST;
         st_q.pwr    <= SPM_CTRL_RST[1:0];
         st_q.ack    <= 1'b0;
         st_q.rdat   <= 32'h0;
         st_q.active <= 1'b0;
      end else begin
         st_q <= st_d;
      end
   end

   assign wb_rsp.ack = st_q.ack;
   assign wb_rsp.dat = st_q.rdat;

endmodule : spm_mode_ctrl

//--- tb/spm_mode_ctrl_properties.sv
/* Port-level checker for the serial port mode slice.
   Bound to spm_mode_ctrl; sees only that module's ports. */
`timescale 1ns/1ns
module spm_mode_ctrl_properties
   import spm_pkg::*;
(
   input wire logic           mclk,         // Clock
   input wire logic           rstn,         // Reset
   input wire spm_wb_req_type wb_req,       // Bus request
   input wire spm_wb_rsp_type wb_rsp,       // Bus answer
   input wire logic           rx_in,        // Line in
   input wire logic           tx_raw,       // Engine bit
   input wire logic           ir_tx_pulse,  // Encoder bit
   input wire logic           ir_rx_bit,    // Decoder bit
   input wire logic           port_ce,      // Port clock
   input wire logic           shift_accept, // Shifter runs
   input wire logic           rx_to_engine, // Bit to engine
   input wire logic           tx_out,       // Tx pin
   input wire logic           ir_active,    // Infrared path
   input wire spm_pin_type    pins          // Ownership
);
   // One domain, so clock and reset are given once
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);

   property p_ack; wb_req.cyc && wb_req.stb && !wb_rsp.ack |=> wb_rsp.ack;
   endproperty
   a_ack: assert property (p_ack)
      else $error("No ack one cycle after request");
   property p_pulse; wb_rsp.ack |=> !wb_rsp.ack; endproperty
   a_pulse: assert property (p_pulse)
      else $error("Ack longer than one cycle");
   property p_zero; wb_rsp.ack |-> wb_rsp.dat[31:24] == 8'h00
      && wb_rsp.dat[21:19] == 3'h0 && !wb_rsp.dat[14]; endproperty
   a_zero: assert property (p_zero)
      else $error("Unimplemented bit read as one");
   property p_idle; !pins.tx_oe |-> tx_out; endproperty
   a_idle: assert property (p_idle)
      else $error("Tx pin not idle while released");
   property p_txm; pins.tx_oe |->
      tx_out == (ir_active ? ir_tx_pulse : tx_raw); endproperty
   a_txm: assert property (p_txm)
      else $error("Tx path wrong");
   property p_rxm; rx_to_engine == (ir_active ? ir_rx_bit : rx_in);
   endproperty
   a_rxm: assert property (p_rxm)
      else $error("Rx path wrong");
   // A disabled port must be quiet: no clock, no shifter, no pins
   property p_off; !pins.port_owns |->
      !(port_ce || shift_accept || ir_active || pins.tx_oe); endproperty
   a_off: assert property (p_off)
      else $error("Disabled port still active");
   property p_rst; $rose(rstn) |-> pins == '0 && !ir_active; endproperty
   a_rst: assert property (p_rst)
      else $error("Port not idle after reset");
endmodule : spm_mode_ctrl_properties

//--- tb/spm_remote_model.sv
/* Remote serial device on the line side of the port.
   Assumes the bench ties its lines to the port's line pins. */
`timescale 1ns/1ns
module spm_remote_model (
   input  wire logic mclk,    // Clock
   input  wire logic tx_line, // From port
   output logic      rx_line, // To port
   output logic      tx_last  // Last bit heard
);
   // Line changes every cycle so a stale value never matches by luck
   initial rx_line = 1'b1;
   always @(posedge mclk) begin
      rx_line <= ~rx_line;
      tx_last <= tx_line;
   end
endmodule : spm_remote_model

//--- tb/testbench.sv
/* Self-checking bench for spm_mode_ctrl.
   Assumes package, checker and remote model are compiled first. */
`timescale 1ns/1ns
module testbench
   import spm_pkg::*;
;
   logic           mclk = 1'b0;
   logic           rstn = 1'b0;
   spm_wb_req_type req  = '0;
   spm_wb_rsp_type rsp;
   logic [3:0]     ce   = 4'h0;
   logic           busy = 1'b0;
   logic           ovf  = 1'b0;
   logic           txr  = 1'b0;
   logic           irtx = 1'b0;
   logic           irrx = 1'b1;
   logic           rxw, pce, acc, r2e, txo, ira;
   spm_pin_type    pins;
   logic [31:0]    rd;
   int             error_cnt = 0;
   int             samples_checked = 0;

   spm_mode_ctrl u_dut (.mclk, .rstn, .wb_req(req), .wb_rsp(rsp),
      .pbus_ce(ce[0]), .sys_ce(ce[1]), .frc_ce(ce[2]), .ref_ce(ce[3]),
      .engine_busy(busy), .rx_overflow(ovf), .rx_in(rxw), .tx_raw(txr),
      .ir_tx_pulse(irtx), .ir_rx_bit(irrx), .port_ce(pce),
      .shift_accept(acc), .rx_to_engine(r2e), .tx_out(txo),
      .ir_active(ira), .pins);
   spm_remote_model u_far (.mclk, .tx_line(txo), .rx_line(rxw), .tx_last());

   // Clock of 100 ns period
   initial begin
      forever #50 mclk = ~mclk;
   end

   task complete_run;
      if (error_cnt == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : complete_run

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task chk1(input string nm, input logic e, input logic g);
      chk(nm, {31'h0, e}, {31'h0, g});
   endtask : chk1

   // Classic cycle: hold until ack is sampled, then release a cycle
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      req <= '{1'b1, 1'b1, w, a, 4'hf, d};
      @(posedge mclk);
      while (rsp.ack !== 1'b1 && n < 20) begin
         @(posedge mclk);
         n++;
      end
      if (n == 20) error_cnt++;
      rd = rsp.dat;
      req <= '0;
      @(posedge mclk);
   endtask : bus

   task t_reg;
      bus(1'b0, SPM_MODE_OFS, 32'h0);
      chk("mode_rst", SPM_MODE_RST, rd);
      bus(1'b1, SPM_MODE_OFS, 32'hffff_ffff);
      bus(1'b0, SPM_MODE_OFS, 32'h0);
      chk("mode_mask", SPM_MODE_WMASK, rd);
      bus(1'b0, 8'h08, 32'h0);
      chk("unmapped", 32'h0, rd);
      busy <= 1'b1;
      @(posedge mclk);
      bus(1'b0, SPM_MODE_OFS, 32'h0);
      chk("active", 32'h0040_0000, rd & 32'h0040_0000);
      busy <= 1'b0;
      // no mode write until status has dropped
      repeat (2) @(posedge mclk);
   endtask : t_reg

   // Only the selected source may reach the port clock
   task t_clk;
      for (int s = 0; s < 4; s++) begin
         bus(1'b1, SPM_MODE_OFS, 32'h8000 | (32'(s) << 17));
         ce <= 4'h1 << s;
         @(negedge mclk);
         chk1("sel_on", 1'b1, pce);
         @(posedge mclk);
         ce <= ~(4'h1 << s);
         @(negedge mclk);
         chk1("sel_off", 1'b0, pce);
         @(posedge mclk);
      end
   endtask : t_clk

   // Chip Sleep and Idle against the mode bits, with overflow raised
   task t_pwr;
      logic [31:0] mv;
      logic        ok;
      ce <= 4'hf;
      ovf <= 1'b1;
      for (int c = 0; c < 3; c++)
         for (int b = 0; b < 8; b++) begin
            mv = 32'h8000;
            mv[23] = b[0];
            mv[13] = b[1];
            mv[16] = b[2];
            ok = !(c == 1 && !b[0]) && !(c == 2 && b[1]);
            bus(1'b1, SPM_CTRL_OFS, 32'(c));
            bus(1'b1, SPM_MODE_OFS, mv);
            @(negedge mclk);
            chk1("port_ce", ok, pce);
            chk1("shift", ok && b[2], acc);
            @(posedge mclk);
         end
      ovf <= 1'b0;
      bus(1'b1, SPM_CTRL_OFS, 32'h0);
   endtask : t_pwr

   task t_pin;
      bus(1'b1, SPM_MODE_OFS, 32'h0000_9600);
      @(negedge mclk);
      chk("pins_a", 32'he, {28'h0, pins});
      chk1("rx_ir", irrx, r2e);
      chk1("tx_ir", irtx, txo);
      @(posedge mclk);
      bus(1'b1, SPM_MODE_OFS, 32'h0000_8100);
      @(negedge mclk);
      chk("pins_b", 32'h9, {28'h0, pins});
      chk1("rx_raw", rxw, r2e);
      chk1("tx_free", 1'b1, txo);
      @(posedge mclk);
      bus(1'b1, SPM_MODE_OFS, 32'h0000_8400);
      @(negedge mclk);
      chk1("tx_raw", txr, txo);
      @(posedge mclk);
      bus(1'b1, SPM_MODE_OFS, 32'h0);
      @(negedge mclk);
      chk("pins_off", 32'h0, {28'h0, pins});
   endtask : t_pin

   // Main sequence after 20 cycles of reset
   initial begin
      repeat (20) @(posedge mclk);
      rstn <= 1'b1;
      t_reg;
      t_clk;
      t_pwr;
      t_pin;
      complete_run;
   end

   // Run needs under 600 cycles; a hang is ended here at 3000
   initial begin
      repeat (3000) @(posedge mclk);
      error_cnt++;
      complete_run;
   end
endmodule : testbench

bind spm_mode_ctrl spm_mode_ctrl_properties u_prop (.mclk, .rstn, .wb_req,
   .wb_rsp, .rx_in, .tx_raw, .ir_tx_pulse, .ir_rx_bit, .port_ce,
   .shift_accept, .rx_to_engine, .tx_out, .ir_active, .pins);
